// file: gigabit_autoneg_next_page_regs.sv
// APB register group for gigabit control/status and auto-negotiation next pages.
// Assumes the engine, status inputs and APB master share clk; only the straps are async.
//
// Decided for this implementation: register access over APB.

`default_nettype none

module gigabit_autoneg_next_page_regs
  import gigabit_np_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] config_strap_pins,
  input wire logic page_sent,
  input wire logic rx_page_valid,
  input wire logic [15:0] rx_page_word,
  input wire phy_status_t phy_stat,
  output logic [15:0] tx_page_word,
  output logic tx_page_valid,
  output gig_cfg_t gig_cfg
);

  state_t st_reg;
  state_t st_next;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic wr_np;
  logic clr_stat;
  logic clr_exp;
  logic idle_inc;
  logic [7:0] idle_base;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
    addr_hit = (a == {{(ADDR_W-6){1'b0}}, idx, 2'b00});
  endfunction

  function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
    wr_merge = old;
    if (s[0])
    begin
      wr_merge[7:0] = d[7:0];
    end
    if (s[1])
    begin
      wr_merge[15:8] = d[15:8];
    end
  endfunction

  always_comb
  begin
    st_next = st_reg;
    setup = psel && !penable;
    access = psel && penable && st_reg.pready;
    wr = access && pwrite && !st_reg.pslverr;
    rd = access && !pwrite;
    wr_np = wr && addr_hit(paddr, IDX_NP_TX);
    clr_stat = rd && addr_hit(paddr, IDX_GIG_STAT);
    clr_exp = rd && addr_hit(paddr, IDX_EXPANSION);

    // Zero wait states: data is captured in setup so that it leaves a flip-flop
    st_next.pready = setup;
    st_next.pslverr = 1'b0;
    if (setup)
    begin
      st_next.prdata = 32'h0000_0000;
      if (addr_hit(paddr, IDX_EXPANSION))
      begin
        st_next.prdata[EXP_PAGE_RX] = st_reg.page_rx;
        st_next.rd_page = st_reg.page_rx;
      end
      else if (addr_hit(paddr, IDX_NP_TX))
      begin
        st_next.prdata[15:0] = st_reg.tx_word;
      end
      else if (addr_hit(paddr, IDX_NP_RX))
      begin
        st_next.prdata[15:0] = st_reg.np_rx;
      end
      else if (addr_hit(paddr, IDX_GIG_CTRL))
      begin
        st_next.prdata[15:0] = st_reg.gc;
      end
      else if (addr_hit(paddr, IDX_GIG_STAT))
      begin
        st_next.prdata[15:0] = {st_reg.fault, st_reg.master, st_reg.lrx, st_reg.rrx,
                                st_reg.partner_fdx, st_reg.partner_hdx, 2'b00, st_reg.idle_cnt};
        st_next.rd_fault = st_reg.fault;
        st_next.rd_idle = st_reg.idle_cnt;
      end
      else
      begin
        st_next.pslverr = 1'b1;
      end
    end

    // Writes to the read-only registers are accepted and dropped
    if (wr_np)
    begin
      st_next.np_tx = wr_merge(st_reg.np_tx, pwdata, pstrb) & NP_TX_WMASK;
    end
    if (wr && addr_hit(paddr, IDX_GIG_CTRL))
    begin
      st_next.gc = wr_merge(st_reg.gc, pwdata, pstrb);
    end

    // A new write and the send of the old page in one cycle leaves the new page pending
    st_next.tx_pending = wr_np || (st_reg.tx_pending && !page_sent);
    if (page_sent)
    begin
      st_next.toggle = !st_reg.toggle;
    end
    st_next.tx_word = {st_next.np_tx[NP_MORE], 1'b0, st_next.np_tx[NP_MSG], st_next.np_tx[NP_ACK2],
                       st_next.toggle, st_next.np_tx[NP_CODE_MSB:0]};

    if (rx_page_valid)
    begin
      st_next.np_rx = rx_page_word;
    end
    if (rx_page_valid)
    begin
      st_next.rd_page = 1'b0;
    end
    // Only a reported flag is cleared, so a page landing after capture survives
    st_next.page_rx = rx_page_valid || (st_reg.page_rx && !(clr_exp && st_reg.rd_page));

    st_next.fault = phy_stat.ms_fault || (st_reg.fault && !(clr_stat && st_reg.rd_fault));
    st_next.master = phy_stat.ms_master;
    st_next.lrx = phy_stat.local_rx_ok;
    st_next.rrx = phy_stat.remote_rx_ok;
    st_next.partner_fdx = phy_stat.partner_1000_fdx;
    st_next.partner_hdx = phy_stat.partner_1000_hdx;

    // Subtracting the reported count keeps errors that land between setup and access
    idle_base = clr_stat ? st_reg.idle_cnt - st_reg.rd_idle : st_reg.idle_cnt;
    idle_inc = phy_stat.idle_error && (idle_base != IDLE_MAX);
    st_next.idle_cnt = idle_inc ? idle_base + 8'h01 : idle_base;

    // Straps settle through the synchroniser before they seed the abilities
    st_next.strap_s1 = config_strap_pins;
    st_next.strap_s2 = st_reg.strap_s1;
    if (st_reg.strap_cnt != 2'h3)
    begin
      st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
    end
    if (st_reg.strap_cnt == STRAP_LOAD_CNT)
    begin
      st_next.gc[GC_FDX] = st_reg.strap_s2[1];
      st_next.gc[GC_HDX] = st_reg.strap_s2[0];
    end

    // Reserved test codes pass through unchanged; their effect is left undefined
    st_next.cfg.test_mode = test_mode_t'(st_next.gc[GC_TEST_HI:GC_TEST_LO]);
    st_next.cfg.ms_manual = st_next.gc[GC_MANUAL];
    st_next.cfg.ms_master_force = st_next.gc[GC_MANUAL] && st_next.gc[GC_MS_VAL];
    st_next.cfg.port_multi = st_next.gc[GC_PORT];
    st_next.cfg.adv_1000_fdx = st_next.gc[GC_FDX];
    st_next.cfg.adv_1000_hdx = st_next.gc[GC_HDX];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign tx_page_word = st_reg.tx_word;
  assign tx_page_valid = st_reg.tx_pending;
  assign gig_cfg = st_reg.cfg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_np_reset;
    $past(srst) |-> (tx_page_word == NP_TX_RESET) && !tx_page_valid && (st_reg.np_rx == 16'h0000);
  endproperty
  a_np_reset: assert property (p_np_reset) else $error("next page registers not at reset value");

  property p_np_write;
    wr_np |=> tx_page_valid && (tx_page_word[NP_MORE] == $past(pstrb[1] ? pwdata[NP_MORE] : tx_page_word[NP_MORE]));
  endproperty
  a_np_write: assert property (p_np_write) else $error("page write not pending or more bit lost");

  property p_toggle;
    page_sent |=> tx_page_word[NP_TOGGLE] != $past(tx_page_word[NP_TOGGLE]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip on page send");

  property p_pending_clear;
    tx_page_valid && page_sent && !wr_np |=> !tx_page_valid;
  endproperty
  a_pending_clear: assert property (p_pending_clear) else $error("page still pending after send");

  property p_rx_page;
    rx_page_valid |=> st_reg.page_rx && (st_reg.np_rx == $past(rx_page_word)) ##1 st_reg.page_rx;
  endproperty
  a_rx_page: assert property (p_rx_page) else $error("received page not latched");

  property p_ms_gate;
    !gig_cfg.ms_manual |-> !gig_cfg.ms_master_force;
  endproperty
  a_ms_gate: assert property (p_ms_gate) else $error("master force active without manual enable");

  property p_cfg_follow;
    wr && addr_hit(paddr, IDX_GIG_CTRL) && pstrb[1] && (st_reg.strap_cnt != STRAP_LOAD_CNT)
      |=> (gig_cfg.test_mode == $past(pwdata[GC_TEST_HI:GC_TEST_LO])) && (gig_cfg.port_multi == $past(pwdata[GC_PORT]));
  endproperty
  a_cfg_follow: assert property (p_cfg_follow) else $error("control write not reflected in config");

  property p_strap;
    (st_reg.strap_cnt == STRAP_LOAD_CNT) |=> gig_cfg.adv_1000_fdx == $past(st_reg.strap_s2[1])
      && gig_cfg.adv_1000_hdx == $past(st_reg.strap_s2[0]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded into abilities");

  property p_fault_latch;
    phy_stat.ms_fault |=> st_reg.fault ##1 (st_reg.fault || $past(clr_stat));
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault not latched");

  property p_fault_hold;
    st_reg.fault && !clr_stat |=> st_reg.fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without a read");

  property p_master_reset;
    $past(srst) |-> st_reg.master;
  endproperty
  a_master_reset: assert property (p_master_reset) else $error("role not master after reset");

  property p_idle_count;
    phy_stat.idle_error && !clr_stat && (st_reg.idle_cnt != IDLE_MAX) |=> st_reg.idle_cnt == $past(st_reg.idle_cnt) + 8'h01;
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("idle error not counted");

  property p_idle_clear;
    clr_stat && !phy_stat.idle_error |=> st_reg.idle_cnt == $past(st_reg.idle_cnt) - $past(st_reg.rd_idle);
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle count not cleared by read");

  property p_apb_answer;
    setup |=> pready ##1 !pready || (psel && !penable);
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

endmodule // gigabit_autoneg_next_page_regs

`default_nettype wire

// file: gigabit_np_pkg.sv
// Constants, carriers and state layout for the gigabit next page register group.
// Assumes one 20 MHz clock and a same-clock auto-negotiation engine beside it.
//
// What this block does
// - Transmit page bit 15 means more pages follow; bits 10:0 hold code; writable.
// - Transmit page bit 13 marks message page when 1, unformatted when 0; resets 1.
// - Transmit page bit 12 says local side can comply; writable, resets 0.
// - Transmit page bit 11 is read-only toggle, inverse of last sent toggle.
// - Receive page bit 12 reads 1 when partner complies with local request.
// - Control bits 15:13 select transmitter test mode; reset to normal.
// - Test modes behave as the standard gigabit copper transmitter test modes.
// - Control bit 12 enables manual master/slave; value bit only counts then.
// - Control bit 11 forces master when 1, slave when 0; resets 0.
// - Control bit 10 declares multi-port or single-port device; resets 0.
// - Control bits 9 and 8 advertise gigabit duplex abilities; reset from straps.
// - Status bit 15 latches high on a master/slave configuration fault.
// - Status bit 14 shows resolved role, 1 master; resets to 1.
// - Status bit 13 reads 1 while the local receiver is okay.
// - Status bit 12 reads 1 while the remote receiver is okay.
// - Status bits 11 and 10 show partner gigabit abilities; reset 0.
// - Status bits 7:0 count idle errors, clear on read, reset to zero.
// - Expansion bit 1 latches when a new partner page arrives.

`default_nettype none

package gigabit_np_pkg;

  localparam logic [3:0] IDX_EXPANSION = 4'h6;
  localparam logic [3:0] IDX_NP_TX = 4'h7;
  localparam logic [3:0] IDX_NP_RX = 4'h8;
  localparam logic [3:0] IDX_GIG_CTRL = 4'h9;
  localparam logic [3:0] IDX_GIG_STAT = 4'ha;

  localparam int NP_MORE = 15;
  localparam int NP_ACK = 14;
  localparam int NP_MSG = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOGGLE = 11;
  localparam int NP_CODE_MSB = 10;
  localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;
  localparam logic [15:0] NP_TX_RESET = 16'h2000;

  localparam int GC_TEST_HI = 15;
  localparam int GC_TEST_LO = 13;
  localparam int GC_MANUAL = 12;
  localparam int GC_MS_VAL = 11;
  localparam int GC_PORT = 10;
  localparam int GC_FDX = 9;
  localparam int GC_HDX = 8;
  localparam logic [15:0] GIG_CTRL_RESET = 16'h0000;

  localparam int GS_FAULT = 15;
  localparam int GS_MASTER = 14;
  localparam int EXP_PAGE_RX = 1;
  localparam logic MASTER_RESET = 1'b1;
  localparam logic [7:0] IDLE_RESET = 8'h00;
  localparam logic [7:0] IDLE_MAX = 8'hff;
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;

  typedef enum logic [2:0] {
    TM_NORMAL = 3'b000,
    TM_WAVEFORM = 3'b001,
    TM_JITTER_MASTER = 3'b010,
    TM_JITTER_SLAVE = 3'b011,
    TM_DISTORTION = 3'b100
  } test_mode_t;

  typedef struct packed {
    logic ms_fault;
    logic ms_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic partner_1000_fdx;
    logic partner_1000_hdx;
    logic idle_error;
  } phy_status_t;

  typedef struct packed {
    test_mode_t test_mode;
    logic ms_manual;
    logic ms_master_force;
    logic port_multi;
    logic adv_1000_fdx;
    logic adv_1000_hdx;
  } gig_cfg_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rd_fault;
    logic rd_page;
    logic [7:0] rd_idle;
    logic [15:0] np_tx;
    logic toggle;
    logic tx_pending;
    logic [15:0] tx_word;
    logic [15:0] np_rx;
    logic page_rx;
    logic fault;
    logic master;
    logic lrx;
    logic rrx;
    logic partner_fdx;
    logic partner_hdx;
    logic [7:0] idle_cnt;
    logic [15:0] gc;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_cnt;
    gig_cfg_t cfg;
  } state_t;

  localparam state_t ST_RESET = '{
    np_tx: NP_TX_RESET,
    tx_word: NP_TX_RESET,
    master: MASTER_RESET,
    idle_cnt: IDLE_RESET,
    gc: GIG_CTRL_RESET,
    cfg: '{test_mode: TM_NORMAL, default: 1'b0},
    default: '0
  };

endpackage

`default_nettype wire

// file: autoneg_partner_model.sv
// Behavioural auto-negotiation engine beside the register group.
// Assumes the bench sets the send delay and commands each partner page.
`default_nettype none

module autoneg_partner_model
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] send_dly,
  input wire logic tx_page_valid,
  input wire logic [15:0] tx_page_word,
  input wire logic rx_go,
  input wire logic [15:0] rx_word,
  output logic page_sent,
  output logic [15:0] last_sent,
  output logic rx_page_valid,
  output logic [15:0] rx_page_word
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt;

  always_ff @(posedge clk)
  begin
    page_sent <= 1'b0;
    rx_page_valid <= rx_go;
    // Idle word keeps flipping so a stale sample cannot pass
    rx_page_word <= rx_go ? rx_word : ~rx_page_word;
    if (srst)
    begin
      cnt <= '0;
      last_sent <= '0;
      rx_page_valid <= 1'b0;
      rx_page_word <= 16'h0000;
    end
    else if (tx_page_valid && !page_sent)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == send_dly)
      begin
        page_sent <= 1'b1;
        cnt <= '0;
        last_sent <= tx_page_word;
      end
    end
  end
endmodule // autoneg_partner_model

`default_nettype wire

// file: gigabit_autoneg_next_page_regs_test.sv
// Self-checking bench for the gigabit next page register group.
// Assumes straps fixed at 2'b10 and the engine modelled by the partner.
`default_nettype none

module gigabit_autoneg_next_page_regs_test
  import gigabit_np_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, send_dly = 4'h0;
  logic [1:0] straps = 2'b10;
  logic [15:0] rx_word = 16'h0000, tx_page_word, last_sent, rx_page_word;
  logic pready, pslverr, page_sent, rx_page_valid, tx_page_valid, er;
  phy_status_t stat = 7'h20;
  gig_cfg_t gig_cfg;
  int err_count = 0;
  int checks = 0;

  always #25 clk = ~clk;

  gigabit_autoneg_next_page_regs i_gigabit_autoneg_next_page_regs (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .config_strap_pins(straps), .page_sent(page_sent),
    .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word), .phy_stat(stat),
    .tx_page_word(tx_page_word), .tx_page_valid(tx_page_valid), .gig_cfg(gig_cfg));

  autoneg_partner_model i_autoneg_partner_model (.clk(clk), .srst(srst), .send_dly(send_dly),
    .tx_page_valid(tx_page_valid), .tx_page_word(tx_page_word), .rx_go(rx_go), .rx_word(rx_word),
    .page_sent(page_sent), .last_sent(last_sent), .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word));

  task conclude;
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task hang;
    err_count++;
    $display("CHECK FAILED at %0t: no answer in time", $time);
    conclude();
  endtask

  // Ready and read data are taken at the rising edge that samples ready high
  task apb(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
        hang();
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [15:0] exp);
    apb(a, 1'b0, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask

  task wait_sent;
    int n;
    n = 0;
    while (tx_page_valid !== 1'b0)
    begin
      @(negedge clk);
      n++;
      if (n > 40)
        hang();
    end
  endtask

  task cfg_chk(input logic [7:0] exp);
    @(posedge clk);
    @(negedge clk);
    chk({24'h0, gig_cfg}, {24'h0, exp});
  endtask

  task t_reset;
    rdchk(8'h1c, 16'h2000);
    rdchk(8'h20, 16'h0000);
    rdchk(8'h24, {6'h00, straps, 8'h00});
    rdchk(8'h28, 16'h4000);
    rdchk(8'h18, 16'h0000);
    chk({16'h0, tx_page_word}, 32'h2000);
    apb(8'h30, 1'b0, 16'h0000);
    chk({31'h0, er}, 32'h1);
  endtask

  task t_tx_page;
    apb(8'h1c, 1'b1, 16'hffff);
    @(negedge clk);
    chk({31'h0, tx_page_valid}, 32'h1);
    chk({16'h0, tx_page_word}, 32'hb7ff);
    wait_sent;
    chk({16'h0, last_sent}, 32'hb7ff);
    rdchk(8'h1c, 16'hbfff);
    // Slow engine: page stays pending across a read
    send_dly <= 4'h5;
    apb(8'h1c, 1'b1, 16'h0001);
    rdchk(8'h1c, 16'h0801);
    wait_sent;
    chk({16'h0, last_sent}, 32'h0801);
    rdchk(8'h1c, 16'h0001);
  endtask

  task t_rx_page;
    @(posedge clk);
    rx_word <= 16'hd5a5;
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    repeat (2) @(posedge clk);
    apb(8'h20, 1'b1, 16'hffff);
    chk({31'h0, er}, 32'h0);
    rdchk(8'h20, 16'hd5a5);
    rdchk(8'h18, 16'h0002);
    rdchk(8'h18, 16'h0000);
  endtask

  task t_ctrl;
    logic [15:0] d;
    for (int m = 0; m < 5; m++)
    begin
      d = {m[2:0], 5'b10101, 8'h00};
      apb(8'h24, 1'b1, d);
      cfg_chk({m[2:0], 5'b10101});
      rdchk(8'h24, d);
    end
    apb(8'h24, 1'b1, 16'h0800);
    cfg_chk(8'h00);
    apb(8'h24, 1'b1, 16'h1800);
    cfg_chk(8'h18);
  endtask

  task t_status;
    @(posedge clk);
    stat <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    @(posedge clk);
    stat.ms_fault <= 1'b0;
    repeat (2) @(posedge clk);
    stat.idle_error <= 1'b0;
    rdchk(8'h28, 16'hb803);
    rdchk(8'h28, 16'h3800);
    stat.ms_fault <= 1'b1;
    stat.ms_master <= 1'b1;
    rdchk(8'h28, 16'hf800);
    rdchk(8'h28, 16'hf800);
    stat.ms_fault <= 1'b0;
    rdchk(8'h28, 16'hf800);
    rdchk(8'h28, 16'h7800);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    t_reset;
    t_tx_page;
    t_rx_page;
    t_ctrl;
    t_status;
    conclude;
  end
endmodule // gigabit_autoneg_next_page_regs_test

`default_nettype wire
